// [hw/adc_regs_cfg.svh]
// Register addresses, field positions, reset values and timing counts of the register bank.
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH

// Register addresses in the device map.
`define ADDR_DEVICE_IDENTITY   6'h00
`define ADDR_EVENT_FLAGS       6'h01
`define ADDR_OPERATING_CONFIG  6'h02

// Reset values.
`define EVENT_FLAGS_RESET      16'h0500
`define OPERATING_CONFIG_RESET 16'h0510

// Event-flags field positions.
`define EF_LOCKED              15
`define EF_RESYNC              14
`define EF_REGMAP              13
`define EF_RX_CRC_ERR          12
`define EF_CRC_POLY            11
`define EF_RESET_SEEN          10
`define EF_WLEN_HI             9
`define EF_WLEN_LO             8
`define EF_CHAN1               1
`define EF_CHAN0               0

// Operating-configuration field positions.
`define OC_REGMAP_CRC_EN       13
`define OC_RX_CRC_EN           12
`define OC_CRC_POLY            11
`define OC_RESET_SEEN          10
`define OC_WLEN_HI             9
`define OC_WLEN_LO             8
`define OC_TIMEOUT_EN          4
`define OC_SRC_HI              3
`define OC_SRC_LO              2
`define OC_IDLE_FLOAT          1
`define OC_PULSE_FORMAT        0

// Bits of the operating-configuration word that the host may change.
`define OC_WRITE_MASK          16'h3B1F

// Identity word fields; both values are arbitrary.
`define ID_UPPER_NIBBLE        4'hA
`define ID_CHANNEL_TOTAL       4'h5
`define ID_LOW_BYTE            8'h00

// Length of the low pulse on the ready pin, in ns, and in clock cycles at 100 MHz.
`define SYS_CLK_MHZ            100
`define SR_PULSE_NS            40
`define SR_PULSE_CYC           ((`SR_PULSE_NS * `SYS_CLK_MHZ) / 1000)

`endif

// [hw/adc_regs_pkg.sv]
// Types shared by the register bank.
package adc_regs_pkg;
    typedef enum logic [1:0] {
        WLEN_16,
        WLEN_24,
        WLEN_32_ZERO_PAD,
        WLEN_32_SIGN_EXT
    } word_length_t;

    typedef enum logic [1:0] {
        SRC_MOST_LAGGING,
        SRC_ANY_ENABLED,
        SRC_MOST_LEADING,
        SRC_MOST_LEADING_ALT
    } ready_source_t;

    typedef enum logic [1:0] {
        PIN_IDLE,
        PIN_PULSE,
        PIN_HOLD
    } pin_state_t;
endpackage : adc_regs_pkg

// [hw/sticky_flag.sv]
// One sticky status flag: set by an event, cleared by a request, set wins over clear.
module sticky_flag #(
    parameter logic RESET_VALUE = 1'b0
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    // Control
    input  wire logic i_set,
    input  wire logic i_clear,
    // State
    output logic      o_flag
);
    logic flag_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flag_q <= RESET_VALUE;
        end else if (i_set) begin
            flag_q <= 1'b1;
        end else if (i_clear) begin
            flag_q <= 1'b0;
        end
    end

    assign o_flag = flag_q;
endmodule : sticky_flag

// [hw/adc_status_mode_registers.sv]
// Identification, event-flags and operating-configuration registers with the ready pin.
// Notes on behaviour
// - Event-flags word is read-only at address one, reset value 0x0500.
// - Bit 15 shows interface lock; reads 0 after reset.
// - Bit 14 sets on every converter resynchronisation; resets to 0.
// - Bit 13 shows that the register-map checksum changed.
// - Bit 12 shows a checksum error on serial input data.
// - Bit 11 shows the active polynomial: 0 CCITT, 1 ANSI.
// - Bit 10 reads 1 after reset until the host clears it.
// - Bits 9:8 show the active word length, same coding as configuration.
// - Bit 1 shows new channel 1 data available.
// - Bit 0 shows new channel 0 data available.
// - Configuration word is read-write at address two, reset value 0x0510.
// - Bit 13 enables the register-map checksum; off at reset.
// - Bit 12 enables checking of the serial input checksum; off at reset.
// - Bit 11 picks the polynomial for all checksums: 0 CCITT, 1 ANSI.
// - Writing 0 to bit 10 clears the reset-seen flag; reads 1 after reset.
// - Bits 9:8 pick word length 16, 24, 32 padded, 32 sign-extended.
// - Bit 4 enables the interface timeout; on at reset.
// - Identity word is read-only: fixed upper nibble, channel count, reserved low byte.
// - Bits 3:2 pick ready source: lagging, OR of enabled, leading.
// - Bit 1 makes the idle ready pin drive high or float.
// - Bit 0 shows data as steady low or fixed-length low pulse.
`include "adc_regs_cfg.svh"

module adc_status_mode_registers #(
    parameter logic [3:0] ID_UPPER      = `ID_UPPER_NIBBLE,
    parameter logic [3:0] ID_CHAN_TOTAL = `ID_CHANNEL_TOTAL,
    parameter logic [7:0] ID_LOW        = `ID_LOW_BYTE,
    parameter int         PULSE_CYCLES  = `SR_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_srst,
    // Register port from the serial frame engine
    input  wire logic [5:0]                  i_reg_addr,
    input  wire logic                        i_reg_wr_en,
    input  wire logic [15:0]                 i_reg_wr_data,
    input  wire logic                        i_reg_rd_en,
    output logic [15:0]                      o_reg_rd_data,
    output logic                             o_reg_rd_valid,
    // Status from the interface and converter
    input  wire logic                        i_spi_locked,
    input  wire logic                        i_resync_pulse,
    input  wire logic                        i_rx_crc_error,
    input  wire logic [15:0]                 i_regmap_crc,
    input  wire logic [1:0]                  i_chan_enable,
    input  wire logic                        i_chan0_new_sample,
    input  wire logic                        i_chan1_new_sample,
    input  wire logic                        i_sample_taken,
    // Configuration outputs
    output logic                             o_regmap_crc_en,
    output logic                             o_rx_crc_en,
    output logic                             o_crc_poly_ansi,
    output adc_regs_pkg::word_length_t       o_word_length_select,
    output logic                             o_timeout_en,
    // Ready pin, output enable low while driving
    output logic                             o_sample_ready_pin_out,
    output logic                             o_sample_ready_pin_oe_n
);
    import adc_regs_pkg::*;

    localparam int PULSE_LEN = (PULSE_CYCLES < 1) ? 1 : PULSE_CYCLES;

    logic [15:0]   config_q;
    logic [15:0]   crc_ref_q;
    logic          locked_q;
    logic [15:0]   rd_data_q;
    logic          rd_valid_q;
    logic [15:0]   pulse_cnt_q;
    pin_state_t    pin_state_q;
    logic          ready_level_q;

    logic          wr_config;
    logic          rd_flags;
    logic          reset_seen;
    logic          resync_seen_flag;
    logic          regmap_changed;
    logic          rx_crc_failed;
    logic          chan0_new_sample;
    logic          chan1_new_sample;
    logic          leading_seen;
    logic          regmap_diff;
    logic          rx_crc_hit;
    logic          lead_set;
    logic          ready_level;
    logic [15:0]   event_flags;
    logic [15:0]   identity;
    ready_source_t sample_ready_source_select;
    logic          sample_ready_idle_float;
    logic          sample_ready_pulse_format;
    logic          pin_active;

    assign wr_config = i_reg_wr_en && (i_reg_addr == `ADDR_OPERATING_CONFIG);
    // Reading the event flags clears the event-type flags; a same-cycle event still wins.
    assign rd_flags  = i_reg_rd_en && (i_reg_addr == `ADDR_EVENT_FLAGS);

    // Configuration storage; only documented writable bits take the host value.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            config_q <= `OPERATING_CONFIG_RESET;
        end else if (wr_config) begin
            config_q <= i_reg_wr_data & `OC_WRITE_MASK;
        end
    end

    assign o_regmap_crc_en           = config_q[`OC_REGMAP_CRC_EN];
    assign o_rx_crc_en               = config_q[`OC_RX_CRC_EN];
    assign o_crc_poly_ansi           = config_q[`OC_CRC_POLY];
    assign o_word_length_select      = word_length_t'(config_q[`OC_WLEN_HI:`OC_WLEN_LO]);
    assign o_timeout_en              = config_q[`OC_TIMEOUT_EN];
    assign sample_ready_source_select =
        ready_source_t'(config_q[`OC_SRC_HI:`OC_SRC_LO]);
    assign sample_ready_idle_float   = config_q[`OC_IDLE_FLOAT];
    assign sample_ready_pulse_format = config_q[`OC_PULSE_FORMAT];

    // Reset-seen flag: set by reset, cleared only by a host write of 0 to its bit.
    sticky_flag #(
        .RESET_VALUE (1'b1)
    ) u_reset_seen (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (1'b0),
        .i_clear   (wr_config && !i_reg_wr_data[`OC_RESET_SEEN]),
        .o_flag    (reset_seen)
    );

    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_resync (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (i_resync_pulse),
        .i_clear   (rd_flags),
        .o_flag    (resync_seen_flag)
    );

    // The reference follows the checksum while disabled and during each host write, so only
    // a change the host did not cause raises the flag. The checksum engine must show the new
    // value in the write cycle itself, since even a one-cycle lag would look like corruption.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            crc_ref_q <= 16'h0000;
        end else if (!config_q[`OC_REGMAP_CRC_EN] || i_reg_wr_en) begin
            crc_ref_q <= i_regmap_crc;
        end
    end

    assign regmap_diff = config_q[`OC_REGMAP_CRC_EN] && !i_reg_wr_en
                         && (i_regmap_crc != crc_ref_q);

    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_regmap (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (regmap_diff),
        .i_clear   (rd_flags),
        .o_flag    (regmap_changed)
    );

    assign rx_crc_hit = i_rx_crc_error && config_q[`OC_RX_CRC_EN];

    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_rx_crc (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (rx_crc_hit),
        .i_clear   (rd_flags),
        .o_flag    (rx_crc_failed)
    );

    // Per-channel availability; a disabled channel never reports new data.
    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_chan0 (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (i_chan0_new_sample && i_chan_enable[0]),
        .i_clear   (i_sample_taken || !i_chan_enable[0]),
        .o_flag    (chan0_new_sample)
    );

    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_chan1 (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (i_chan1_new_sample && i_chan_enable[1]),
        .i_clear   (i_sample_taken || !i_chan_enable[1]),
        .o_flag    (chan1_new_sample)
    );

    assign lead_set = (i_chan0_new_sample && i_chan_enable[0])
                      || (i_chan1_new_sample && i_chan_enable[1]);

    // Latches the first enabled channel to finish until the samples are taken.
    sticky_flag #(
        .RESET_VALUE (1'b0)
    ) u_leading (
        .i_sys_clk (i_sys_clk),
        .i_srst    (i_srst),
        .i_set     (lead_set),
        .i_clear   (i_sample_taken),
        .o_flag    (leading_seen)
    );

    // Lock comes from the frame engine on the same clock; held here so reads are stable.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            locked_q <= 1'b0;
        end else begin
            locked_q <= i_spi_locked;
        end
    end

    always_comb begin
        event_flags                            = 16'h0000;
        event_flags[`EF_LOCKED]                = locked_q;
        event_flags[`EF_RESYNC]                = resync_seen_flag;
        event_flags[`EF_REGMAP]                = regmap_changed;
        event_flags[`EF_RX_CRC_ERR]            = rx_crc_failed;
        event_flags[`EF_CRC_POLY]              = config_q[`OC_CRC_POLY];
        event_flags[`EF_RESET_SEEN]            = reset_seen;
        event_flags[`EF_WLEN_HI:`EF_WLEN_LO]   = config_q[`OC_WLEN_HI:`OC_WLEN_LO];
        event_flags[`EF_CHAN1]                 = chan1_new_sample;
        event_flags[`EF_CHAN0]                 = chan0_new_sample;
    end

    assign identity = {ID_UPPER, ID_CHAN_TOTAL, ID_LOW};

    // Read port: one cycle from request to data; unmapped addresses read zero.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_data_q <= 16'h0000;
        end else if (i_reg_rd_en) begin
            case (i_reg_addr)
                `ADDR_DEVICE_IDENTITY: begin
                    rd_data_q <= identity;
                end
                `ADDR_EVENT_FLAGS: begin
                    rd_data_q <= event_flags;
                end
                `ADDR_OPERATING_CONFIG: begin
                    // The reset bit reads the live flag so software sees its clear take effect.
                    rd_data_q <= {config_q[15:11], reset_seen, config_q[9:0]};
                end
                default: begin
                    rd_data_q <= 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= i_reg_rd_en;
        end
    end

    assign o_reg_rd_data  = rd_data_q;
    assign o_reg_rd_valid = rd_valid_q;

    // Ready level per source selection; with no channel enabled only a leading latch set earlier can assert it.
    always_comb begin
        case (sample_ready_source_select)
            SRC_MOST_LAGGING: begin
                ready_level = (i_chan_enable != 2'b00)
                              && (!i_chan_enable[0] || chan0_new_sample)
                              && (!i_chan_enable[1] || chan1_new_sample);
            end
            SRC_ANY_ENABLED: begin
                ready_level = chan0_new_sample || chan1_new_sample;
            end
            SRC_MOST_LEADING, SRC_MOST_LEADING_ALT: begin
                ready_level = leading_seen;
            end
            default: begin
                ready_level = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ready_level_q <= 1'b0;
        end else begin
            ready_level_q <= ready_level;
        end
    end

    // Pin sequencer: a rising ready level starts either a steady low or a fixed pulse.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pin_state_q <= PIN_IDLE;
            pulse_cnt_q <= 16'h0000;
        end else begin
            case (pin_state_q)
                PIN_IDLE: begin
                    if (ready_level && !ready_level_q) begin
                        if (sample_ready_pulse_format) begin
                            pin_state_q <= PIN_PULSE;
                            pulse_cnt_q <= 16'(PULSE_LEN - 1);
                        end else begin
                            pin_state_q <= PIN_HOLD;
                        end
                    end
                end
                PIN_PULSE: begin
                    if (pulse_cnt_q == 16'h0000) begin
                        pin_state_q <= PIN_IDLE;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q - 16'h0001;
                    end
                end
                PIN_HOLD: begin
                    if (!ready_level) begin
                        pin_state_q <= PIN_IDLE;
                    end
                end
                default: begin
                    pin_state_q <= PIN_IDLE;
                end
            endcase
        end
    end

    // The pin is active low; a pulse is not cut short if the data are taken early.
    assign pin_active              = (pin_state_q != PIN_IDLE);
    assign o_sample_ready_pin_out  = !pin_active;
    assign o_sample_ready_pin_oe_n = sample_ready_idle_float && !pin_active;
endmodule : adc_status_mode_registers

// [tb/adc_regs_properties.sv]
// Concurrent checks on the ports of the status and mode register bank.
module adc_regs_properties #(
    parameter logic [3:0] ID_UPPER      = 4'h0,
    parameter logic [3:0] ID_CHAN_TOTAL = 4'h0
) (
    // Clock and reset
    input wire logic                       i_sys_clk,
    input wire logic                       i_srst,
    // Register port
    input wire logic [5:0]                 i_reg_addr,
    input wire logic                       i_reg_wr_en,
    input wire logic [15:0]                i_reg_wr_data,
    input wire logic                       i_reg_rd_en,
    input wire logic [15:0]                o_reg_rd_data,
    input wire logic                       o_reg_rd_valid,
    // Events and configuration
    input wire logic                       i_resync_pulse,
    input wire logic                       o_regmap_crc_en,
    input wire logic                       o_rx_crc_en,
    input wire logic                       o_crc_poly_ansi,
    input wire adc_regs_pkg::word_length_t o_word_length_select,
    input wire logic                       o_timeout_en,
    // Ready pin
    input wire logic                       o_sample_ready_pin_out,
    input wire logic                       o_sample_ready_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import adc_regs_pkg::*;
    logic [15:0] wd_q;
    // Write data is kept one cycle so that a write can be compared with its effect.
    always_ff @(posedge i_sys_clk) begin
        wd_q <= i_reg_wr_data;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    a_rd_valid_pulse: assert property (o_reg_rd_valid == $past(i_reg_rd_en))
        else $error("read valid not one cycle after read");
    a_flags_rsvd_zero: assert property (o_reg_rd_valid && $past(i_reg_addr) == 6'h01
        |-> o_reg_rd_data[7:2] == 6'h00) else $error("reserved flag bits not zero");
    a_id_constant: assert property (o_reg_rd_valid && $past(i_reg_addr) == 6'h00
        |-> o_reg_rd_data[15:8] == {ID_UPPER, ID_CHAN_TOTAL}) else $error("identity wrong");
    a_unmapped_zero: assert property (o_reg_rd_valid && $past(i_reg_addr) > 6'h02
        |-> o_reg_rd_data == 16'h0000) else $error("unmapped read not zero");
    a_flags_mirror: assert property (o_reg_rd_valid && $past(i_reg_addr) == 6'h01
        && !$past(i_reg_wr_en) |-> o_reg_rd_data[11] == o_crc_poly_ansi
        && o_reg_rd_data[9:8] == o_word_length_select) else $error("flags disagree with mode");
    a_cfg_write: assert property (i_reg_wr_en && i_reg_addr == 6'h02 |=>
        {o_regmap_crc_en, o_rx_crc_en, o_crc_poly_ansi, o_word_length_select, o_timeout_en}
        == {wd_q[13:11], wd_q[9:8], wd_q[4]}) else $error("config write not applied");
    a_cfg_hold: assert property (i_reg_wr_en && i_reg_addr != 6'h02
        |=> $stable(o_word_length_select) && $stable(o_timeout_en)) else $error("config changed");
    a_float_idle: assert property (o_sample_ready_pin_oe_n |-> o_sample_ready_pin_out)
        else $error("ready pin floats while showing data");
    a_reset_values: assert property ($fell(i_srst) |-> o_timeout_en && !o_regmap_crc_en
        && !o_rx_crc_en && !o_crc_poly_ansi && o_word_length_select == WLEN_24
        && !o_reg_rd_valid && o_sample_ready_pin_out) else $error("bad state after reset");
    a_resync_sets: assert property (i_resync_pulse ##1 (i_reg_rd_en && i_reg_addr == 6'h01)
        |=> o_reg_rd_data[14]) else $error("resync flag not set");
endmodule : adc_regs_properties

// [tb/host_ready_model.sv]
// Host side of the ready pin: pull-up on the line and a delayed sample take.
module host_ready_model #(
    parameter int TAKE_DELAY = 6
) (
    input  wire logic i_sys_clk,
    input  wire logic i_pin_out,
    input  wire logic i_pin_oe_n,
    output logic      o_pin_wire,
    output logic      o_sample_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // A floating line is pulled up, so idle always reads high at the host.
    assign o_pin_wire = i_pin_oe_n ? 1'b1 : i_pin_out;
    initial begin
        cnt = 0;
        o_sample_taken = 1'b0;
    end
    // The host reads the data some cycles after seeing the line low, like a slow frame.
    always @(negedge i_sys_clk) begin
        o_sample_taken <= (cnt == 1);
        if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (o_pin_wire === 1'b0) begin
            cnt <= TAKE_DELAY;
        end
    end
endmodule : host_ready_model

// [tb/testbench.sv]
// Testbench top: register accesses, event pulses and ready-pin timing.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_regs_pkg::*;
    localparam int         PULSE = 4;
    localparam logic [3:0] ID_U  = 4'h3; // Arbitrary value.
    localparam logic [3:0] ID_C  = 4'h6; // Arbitrary value.
    logic         sys_clk, srst, wr_en, rd_en, rd_valid, locked, resync, rx_err, chan0, chan1;
    logic         taken, regmap_en, rx_en, poly, tmo, pin_out, oe_n, pin;
    logic [5:0]   addr;
    logic [15:0]  wr_data, rd_data, regmap_crc, v;
    logic [1:0]   chan_en;
    word_length_t wlen;
    int           err_count, n_compared, cyc, n;

    adc_status_mode_registers #(.ID_UPPER(ID_U), .ID_CHAN_TOTAL(ID_C), .PULSE_CYCLES(PULSE)) dut (
        .i_sys_clk(sys_clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
        .i_reg_wr_data(wr_data), .i_reg_rd_en(rd_en), .o_reg_rd_data(rd_data),
        .o_reg_rd_valid(rd_valid), .i_spi_locked(locked), .i_resync_pulse(resync),
        .i_rx_crc_error(rx_err), .i_regmap_crc(regmap_crc), .i_chan_enable(chan_en),
        .i_chan0_new_sample(chan0), .i_chan1_new_sample(chan1), .i_sample_taken(taken),
        .o_regmap_crc_en(regmap_en), .o_rx_crc_en(rx_en), .o_crc_poly_ansi(poly),
        .o_word_length_select(wlen), .o_timeout_en(tmo), .o_sample_ready_pin_out(pin_out),
        .o_sample_ready_pin_oe_n(oe_n));
    host_ready_model host (.i_sys_clk(sys_clk), .i_pin_out(pin_out), .i_pin_oe_n(oe_n),
        .o_pin_wire(pin), .o_sample_taken(taken));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk1
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {addr, wr_data, wr_en} = {a, d, 1'b1};
        @(negedge sys_clk);
        wr_en = 1'b0;
    endtask : wr
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp, input logic [15:0] msk);
        @(negedge sys_clk);
        {addr, rd_en} = {a, 1'b1};
        @(negedge sys_clk);
        rd_en = 1'b0;
        chk1(rd_valid, 1'b1);
        chk(rd_data & msk, exp);
    endtask : rdc
    task automatic ev(input int k);
        @(negedge sys_clk);
        {resync, rx_err, chan0, chan1} = {k == 0, k == 1, k == 2, k == 3};
        @(negedge sys_clk);
        {resync, rx_err, chan0, chan1} = 4'h0;
    endtask : ev
    // Counts the cycles of the next low stretch on the host's view of the pin.
    task automatic low_len(output int len);
        int w;
        len = 0;
        w = 0;
        while (pin !== 1'b0 && w < 20) begin
            @(negedge sys_clk);
            w++;
        end
        while (pin === 1'b0 && len < 40) begin
            @(negedge sys_clk);
            len++;
        end
    endtask : low_len
    task automatic final_report();
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        {srst, wr_en, rd_en, locked, resync, rx_err, chan0, chan1} = 8'h80;
        {addr, wr_data, regmap_crc, chan_en} = {6'h00, 16'h0000, 16'h0000, 2'b11};
        {err_count, n_compared, cyc} = {32'd0, 32'd0, 32'd0};
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        rdc(6'h01, 16'h0500, 16'hFFFF);
        rdc(6'h02, 16'h0510, 16'hFFFF);
        rdc(6'h00, {ID_U, ID_C, 8'h00}, 16'hFF00);
        rdc(6'h05, 16'h0000, 16'hFFFF);
        wr(6'h01, 16'hFFFF);
        wr(6'h00, 16'hFFFF);
        rdc(6'h01, 16'h0500, 16'hFFFF);
        wr(6'h02, 16'h0010);
        rdc(6'h01, 16'h0000, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            v = 16'(i) << 8 | 16'(i & 1) << 11 | 16'(i & 2) << 3;
            wr(6'h02, v);
            rdc(6'h01, v & 16'h0B00, 16'hFFFF);
            rdc(6'h02, v, 16'hFFFF);
            chk(16'(wlen), 16'(i));
            chk1(tmo, v[4]);
        end
        wr(6'h02, 16'h0100);
        ev(1);
        rdc(6'h01, 16'h0100, 16'hFFFF);
        wr(6'h02, 16'h3100);
        ev(1);
        rdc(6'h01, 16'h1100, 16'hFFFF);
        @(negedge sys_clk);
        regmap_crc = 16'h1234;
        rdc(6'h01, 16'h2100, 16'hFFFF);
        wr(6'h02, 16'h0100);
        ev(0);
        rdc(6'h01, 16'h4100, 16'hDFFF);
        // A read issued right behind the pulse must already see the flag.
        @(negedge sys_clk);
        resync = 1'b1;
        @(negedge sys_clk);
        {resync, addr, rd_en} = {1'b0, 6'h01, 1'b1};
        @(negedge sys_clk);
        rd_en = 1'b0;
        chk(rd_data & 16'h4000, 16'h4000);
        locked = 1'b1;
        rdc(6'h01, 16'h8000, 16'h8000);
        locked = 1'b0;
        ev(2);
        rdc(6'h01, 16'h0001, 16'h0003);
        chk1(pin, 1'b1);
        ev(3);
        rdc(6'h01, 16'h0003, 16'h0003);
        chk1(pin, 1'b0);
        repeat (12) @(negedge sys_clk);
        rdc(6'h01, 16'h0100, 16'hFFFF);
        wr(6'h02, 16'h0105);
        ev(2);
        low_len(n);
        chk(16'(n), 16'(PULSE));
        repeat (12) @(negedge sys_clk);
        wr(6'h02, 16'h010A);
        chk1(oe_n, 1'b1);
        ev(3);
        low_len(n);
        chk1(n > 0, 1'b1);
        // Only channel 0 enabled: channel 1 pulses are refused and channel 0 leads alone.
        repeat (12) @(negedge sys_clk);
        chan_en = 2'b01;
        wr(6'h02, 16'h010C);
        ev(3);
        rdc(6'h01, 16'h0100, 16'hFFFF);
        chk1(pin, 1'b1);
        ev(2);
        low_len(n);
        chk1(n > 0, 1'b1);
        repeat (12) @(negedge sys_clk);
        srst = 1'b1;
        repeat (2) @(negedge sys_clk);
        srst = 1'b0;
        rdc(6'h02, 16'h0510, 16'hFFFF);
        rdc(6'h01, 16'h0500, 16'hFFFF);
        final_report();
    end
endmodule : testbench

bind adc_status_mode_registers adc_regs_properties #(
    .ID_UPPER(ID_UPPER), .ID_CHAN_TOTAL(ID_CHAN_TOTAL)) u_props (
    .i_sys_clk, .i_srst, .i_reg_addr, .i_reg_wr_en, .i_reg_wr_data, .i_reg_rd_en,
    .o_reg_rd_data, .o_reg_rd_valid, .i_resync_pulse, .o_regmap_crc_en, .o_rx_crc_en,
    .o_crc_poly_ansi, .o_word_length_select, .o_timeout_en, .o_sample_ready_pin_out,
    .o_sample_ready_pin_oe_n);
